// [design/bfx_exec_top.sv]
/*
 * Bit, flag and transfer executor with its register file, status flags and
 * an AHB-Lite register slave that issues commands and reads back state.
 * Assumes a data memory with combinational read from the registered address
 * and an I/O space that applies the set or clear strobes itself.
 */
// Design decisions made here: the register offsets and register access over AHB-Lite.
// Behaviour
// - Logical shifts move bits one place, fill with zero, one cycle.
// - Rotate left takes carry into bit 0, bit 7 to carry, flags.
// - Rotate right takes carry into bit 7, bit 0 to carry, flags.
// - Arithmetic right shift keeps bit 7, updates Z C N V, one cycle.
// - I/O bit set writes one to the selected bit only, one cycle.
// - I/O bit clear writes zero to the selected bit, no flags.
// - Register bit copied into transfer flag only, one cycle.
// - Transfer flag copied into register bit, no flags, one cycle.
// - Indexed flag set forces one status bit high, one cycle.
// - Indexed flag clear forces one status bit low, one cycle.
// - Post-increment pointer read loads then adds one, two cycles.
// - Pre-decrement pointer read subtracts one then loads, two cycles.
// - Direct read loads the constant address in two cycles.
// - Post-increment pointer write through X or Y stores then adds one, two cycles.
// - Pre-decrement pointer write through X or Y subtracts one then stores, two cycles.
`timescale 1ns/1ps
module bfx_exec_top (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic [31:0] hrdata,
	output logic hresp,
	output logic [15:0] mem_addr,
	output logic [7:0] mem_wdata,
	output logic mem_we,
	output logic mem_re,
	input wire logic [7:0] mem_rdata,
	output logic [5:0] io_addr,
	output logic [2:0] io_bit,
	output logic io_set,
	output logic io_clr
);
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_EXEC,
		ST_MEM
	} bfx_state_t;

	typedef struct packed {
		bfx_state_t state;
		logic dp_valid;
		logic dp_write;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
		logic [31:0] cmd;
		logic [15:0] operand;
		logic refused;
		logic [7:0] flags;
		logic [15:0][7:0] gpr;
		logic [15:0] mem_addr;
		logic [7:0] mem_wdata;
		logic mem_we;
		logic mem_re;
		logic [5:0] io_addr;
		logic [2:0] io_bit;
		logic io_set;
		logic io_clr;
	} bfx_regs_t;

	bfx_regs_t q;
	bfx_regs_t next_q;
	logic [1:0] rst_sync;
	logic rst_n;
	bfx_pkg::bfx_op_t op;
	bfx_pkg::bfx_psel_t psel;
	bfx_pkg::bfx_pmode_t pmode;
	logic [3:0] dst;
	logic [3:0] src;
	logic [2:0] bsel;
	logic [7:0] imm;
	logic [3:0] plo;
	logic [3:0] phi;
	logic [15:0] ptr;
	logic [15:0] ptr_dec;
	logic [15:0] ptr_inc;
	logic [7:0] sh_result;
	logic [7:0] sh_flags;
	logic [3:0] gpr_idx;

	// Reset is released through two stages so its removal is clean.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rst_sync <= 2'b00;
		end else begin
			rst_sync <= {rst_sync[0], 1'b1};
		end
	end
	assign rst_n = rst_sync[1];

	// Command fields of the command in flight.
	assign op = bfx_pkg::bfx_op_t'(q.cmd[bfx_pkg::CMD_OP +: 5]);
	assign psel = bfx_pkg::bfx_psel_t'(q.cmd[bfx_pkg::CMD_PSEL +: 2]);
	assign pmode = bfx_pkg::bfx_pmode_t'(q.cmd[bfx_pkg::CMD_PMODE +: 2]);
	assign dst = q.cmd[bfx_pkg::CMD_DST +: 4];
	assign src = q.cmd[bfx_pkg::CMD_SRC +: 4];
	assign bsel = q.cmd[bfx_pkg::CMD_BIT +: 3];
	assign imm = q.cmd[bfx_pkg::CMD_IMM +: 8];
	assign gpr_idx = q.dp_addr[5:2];

	// Pointer pair selection and its neighbours.
	assign plo = (psel == bfx_pkg::PSEL_X) ? bfx_pkg::PTR_X_LO :
		(psel == bfx_pkg::PSEL_Y) ? bfx_pkg::PTR_Y_LO : bfx_pkg::PTR_Z_LO;
	assign phi = plo + 4'h1;
	assign ptr = {q.gpr[phi], q.gpr[plo]};
	assign ptr_dec = ptr - 16'h0001;
	assign ptr_inc = ptr + 16'h0001;

	bfx_shift_unit u_shift (
		.op(op),
		.operand(q.gpr[dst]),
		.flags_in(q.flags),
		.result(sh_result),
		.flags_out(sh_flags)
	);

	// Read view of the register map, sampled in the address phase.
	function automatic logic [31:0] read_map(input logic [7:0] a);
		logic [31:0] d;
		d = 32'h0000_0000;
		if (a == bfx_pkg::ADDR_CMD) begin
			d = q.cmd;
		end else if (a == bfx_pkg::ADDR_OPERAND) begin
			d = {16'h0000, q.operand};
		end else if (a == bfx_pkg::ADDR_STATUS) begin
			d[bfx_pkg::STAT_BUSY] = (q.state != ST_IDLE);
			d[bfx_pkg::STAT_REFUSED] = q.refused;
		end else if (a == bfx_pkg::ADDR_FLAGS) begin
			d = {24'h00_0000, q.flags};
		end else if (a >= bfx_pkg::ADDR_GPR_BASE && a <= bfx_pkg::ADDR_GPR_LAST) begin
			d = {24'h00_0000, q.gpr[a[5:2]]};
		end
		return d;
	endfunction

	// Whole next-state computation: bus slave, then the executor.
	always_comb begin
		next_q = q;
		next_q.mem_we = 1'b0;
		next_q.mem_re = 1'b0;
		next_q.io_set = 1'b0;
		next_q.io_clr = 1'b0;
		next_q.hrdata = 32'h0000_0000;
		// Zero wait states, so every accepted address phase is one cycle.
		if (hready) begin
			next_q.dp_valid = hsel && htrans[1];
			next_q.dp_write = hwrite;
			next_q.dp_addr = {haddr[7:2], 2'b00};
			if (hsel && htrans[1] && !hwrite) begin
				next_q.hrdata = read_map({haddr[7:2], 2'b00});
			end
		end
		// Data phase of a write. Unmapped offsets are dropped silently.
		if (q.dp_valid && q.dp_write) begin
			if (q.dp_addr == bfx_pkg::ADDR_CMD) begin
				// A command while one is running would corrupt it, so refuse it.
				if (q.state == ST_IDLE) begin
					next_q.cmd = hwdata;
					next_q.state = ST_EXEC;
				end else begin
					next_q.refused = 1'b1;
				end
			end else if (q.dp_addr == bfx_pkg::ADDR_OPERAND) begin
				next_q.operand = hwdata[15:0];
			end else if (q.dp_addr == bfx_pkg::ADDR_STATUS) begin
				if (hwdata[bfx_pkg::STAT_REFUSED]) begin
					next_q.refused = 1'b0;
				end
			end else if (q.state != ST_IDLE) begin
				// Flags and registers belong to the executor while busy.
				if (q.dp_addr == bfx_pkg::ADDR_FLAGS ||
					(q.dp_addr >= bfx_pkg::ADDR_GPR_BASE &&
					q.dp_addr <= bfx_pkg::ADDR_GPR_LAST)) begin
					next_q.refused = 1'b1;
				end
			end else if (q.dp_addr == bfx_pkg::ADDR_FLAGS) begin
				next_q.flags = hwdata[7:0];
			end else if (q.dp_addr >= bfx_pkg::ADDR_GPR_BASE &&
				q.dp_addr <= bfx_pkg::ADDR_GPR_LAST) begin
				next_q.gpr[gpr_idx] = hwdata[7:0];
			end
		end
		// Executor.
		case (q.state)
		ST_IDLE: begin
			next_q.mem_addr = q.mem_addr;
		end
		ST_EXEC: begin
			next_q.state = ST_IDLE;
			case (op)
			bfx_pkg::OP_SHIFT_LEFT_LOGICAL,
			bfx_pkg::OP_SHIFT_RIGHT_LOGICAL,
			bfx_pkg::OP_ROTATE_LEFT_CARRY,
			bfx_pkg::OP_ROTATE_RIGHT_CARRY,
			bfx_pkg::OP_SHIFT_RIGHT_ARITH,
			bfx_pkg::OP_NIBBLE_SWAP: begin
				next_q.gpr[dst] = sh_result;
				next_q.flags = sh_flags;
			end
			bfx_pkg::OP_INDEXED_FLAG_SET: begin
				next_q.flags[bsel] = 1'b1;
			end
			bfx_pkg::OP_INDEXED_FLAG_CLEAR: begin
				next_q.flags[bsel] = 1'b0;
			end
			bfx_pkg::OP_IO_BIT_SET: begin
				next_q.io_addr = imm[5:0];
				next_q.io_bit = bsel;
				next_q.io_set = 1'b1;
			end
			bfx_pkg::OP_IO_BIT_CLEAR: begin
				next_q.io_addr = imm[5:0];
				next_q.io_bit = bsel;
				next_q.io_clr = 1'b1;
			end
			bfx_pkg::OP_REG_BIT_TO_TFLAG: begin
				next_q.flags[bfx_pkg::FL_T] = q.gpr[src][bsel];
			end
			bfx_pkg::OP_TFLAG_TO_REG_BIT: begin
				next_q.gpr[dst][bsel] = q.flags[bfx_pkg::FL_T];
			end
			bfx_pkg::OP_REG_COPY: begin
				next_q.gpr[dst] = q.gpr[src];
			end
			bfx_pkg::OP_IMMEDIATE_LOAD: begin
				next_q.gpr[dst] = imm;
			end
			bfx_pkg::OP_POINTER_READ: begin
				// First of two cycles: present the address, apply pre-decrement.
				next_q.state = ST_MEM;
				next_q.mem_re = 1'b1;
				next_q.mem_addr = ptr;
				if (pmode == bfx_pkg::PMODE_PREDEC) begin
					next_q.mem_addr = ptr_dec;
					next_q.gpr[plo] = ptr_dec[7:0];
					next_q.gpr[phi] = ptr_dec[15:8];
				end
				if (psel == bfx_pkg::PSEL_NONE || pmode == bfx_pkg::PMODE_NONE) begin
					next_q.state = ST_IDLE;
					next_q.mem_re = 1'b0;
					next_q.refused = 1'b1;
				end
			end
			bfx_pkg::OP_DIRECT_MEM_READ: begin
				next_q.state = ST_MEM;
				next_q.mem_re = 1'b1;
				next_q.mem_addr = q.operand;
			end
			bfx_pkg::OP_POINTER_WRITE: begin
				next_q.state = ST_MEM;
				next_q.mem_we = 1'b1;
				next_q.mem_wdata = q.gpr[src];
				next_q.mem_addr = ptr;
				if (pmode == bfx_pkg::PMODE_PREDEC) begin
					next_q.mem_addr = ptr_dec;
					next_q.gpr[plo] = ptr_dec[7:0];
					next_q.gpr[phi] = ptr_dec[15:8];
				end
				// Stores through Z are outside this block and are refused.
				if (psel == bfx_pkg::PSEL_Z || psel == bfx_pkg::PSEL_NONE ||
					pmode == bfx_pkg::PMODE_NONE) begin
					next_q.state = ST_IDLE;
					next_q.mem_we = 1'b0;
					next_q.refused = 1'b1;
				end
			end
			default: begin
				next_q.refused = 1'b1;
			end
			endcase
		end
		ST_MEM: begin
			// Second cycle: capture read data and apply post-increment.
			next_q.state = ST_IDLE;
			if (op != bfx_pkg::OP_POINTER_WRITE) begin
				next_q.gpr[dst] = mem_rdata;
			end
			if (op != bfx_pkg::OP_DIRECT_MEM_READ && pmode == bfx_pkg::PMODE_POSTINC) begin
				next_q.gpr[plo] = ptr_inc[7:0];
				next_q.gpr[phi] = ptr_inc[15:8];
			end
			// A post-increment into the destination pair loses to the load.
			if (op == bfx_pkg::OP_POINTER_READ && (dst == plo || dst == phi)) begin
				next_q.gpr[dst] = mem_rdata;
			end
		end
		default: begin
			next_q.state = ST_IDLE;
		end
		endcase
	end

	// Single state register for the whole block.
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
			q.state <= ST_IDLE;
			q.cmd <= bfx_pkg::CMD_RST;
			q.operand <= bfx_pkg::OPERAND_RST;
			q.flags <= bfx_pkg::FLAGS_RST;
		end else begin
			q <= next_q;
		end
	end

	// Ready and response tied off; read data and strobes straight from flops.
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = q.hrdata;
	assign mem_addr = q.mem_addr;
	assign mem_wdata = q.mem_wdata;
	assign mem_we = q.mem_we;
	assign mem_re = q.mem_re;
	assign io_addr = q.io_addr;
	assign io_bit = q.io_bit;
	assign io_set = q.io_set;
	assign io_clr = q.io_clr;
endmodule // bfx_exec_top

// [design/bfx_pkg.sv]
/*
 * Constants, types and register map of the bit, flag and transfer executor.
 * Assumes a single clock domain and a 32-bit AHB-Lite register bus.
 */
package bfx_pkg;
	// Register byte offsets on the bus.
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_OPERAND = 8'h04;
	localparam logic [7:0] ADDR_STATUS = 8'h08;
	localparam logic [7:0] ADDR_FLAGS = 8'h0C;
	localparam logic [7:0] ADDR_GPR_BASE = 8'h40;
	localparam logic [7:0] ADDR_GPR_LAST = 8'h7C;

	// Command word field positions.
	localparam int CMD_OP = 0;
	localparam int CMD_BIT = 5;
	localparam int CMD_DST = 8;
	localparam int CMD_SRC = 12;
	localparam int CMD_PSEL = 16;
	localparam int CMD_PMODE = 18;
	localparam int CMD_IMM = 24;

	// Status register bits.
	localparam int STAT_BUSY = 0;
	localparam int STAT_REFUSED = 1;

	// Flag positions inside status_flags.
	localparam int FL_C = 0;
	localparam int FL_Z = 1;
	localparam int FL_N = 2;
	localparam int FL_V = 3;
	localparam int FL_S = 4;
	localparam int FL_H = 5;
	localparam int FL_T = 6;
	localparam int FL_I = 7;

	// Reset values.
	localparam logic [7:0] FLAGS_RST = 8'h00;
	localparam logic [31:0] CMD_RST = 32'h0000_0000;
	localparam logic [15:0] OPERAND_RST = 16'h0000;

	// Low byte index of each pointer pair in the 16-entry register file.
	localparam logic [3:0] PTR_X_LO = 4'hA;
	localparam logic [3:0] PTR_Y_LO = 4'hC;
	localparam logic [3:0] PTR_Z_LO = 4'hE;

	// Execution cycles counted from the first edge after the command write.
	localparam int CYC_SINGLE = 1;
	localparam int CYC_MEM = 2;

	typedef enum logic [4:0] {
		OP_SHIFT_LEFT_LOGICAL,
		OP_SHIFT_RIGHT_LOGICAL,
		OP_ROTATE_LEFT_CARRY,
		OP_ROTATE_RIGHT_CARRY,
		OP_SHIFT_RIGHT_ARITH,
		OP_NIBBLE_SWAP,
		OP_INDEXED_FLAG_SET,
		OP_INDEXED_FLAG_CLEAR,
		OP_IO_BIT_SET,
		OP_IO_BIT_CLEAR,
		OP_REG_BIT_TO_TFLAG,
		OP_TFLAG_TO_REG_BIT,
		OP_REG_COPY,
		OP_IMMEDIATE_LOAD,
		OP_POINTER_READ,
		OP_DIRECT_MEM_READ,
		OP_POINTER_WRITE
	} bfx_op_t;

	typedef enum logic [1:0] {
		PSEL_X,
		PSEL_Y,
		PSEL_Z,
		PSEL_NONE
	} bfx_psel_t;

	typedef enum logic [1:0] {
		PMODE_PLAIN,
		PMODE_POSTINC,
		PMODE_PREDEC,
		PMODE_NONE
	} bfx_pmode_t;
endpackage

// [design/bfx_shift_unit.sv]
/*
 * Combinational shift, rotate and nibble swap unit with its flag results.
 * Assumes the caller selects the op and keeps flags it does not want.
 */
`timescale 1ns/1ps
module bfx_shift_unit (
	input wire bfx_pkg::bfx_op_t op,
	input wire logic [7:0] operand,
	input wire logic [7:0] flags_in,
	output logic [7:0] result,
	output logic [7:0] flags_out
);
	logic [7:0] r;
	logic c;
	logic nf;

	// Result and carry per op, then the shared flag terms.
	always_comb begin
		r = operand;
		c = flags_in[bfx_pkg::FL_C];
		flags_out = flags_in;
		case (op)
		bfx_pkg::OP_SHIFT_LEFT_LOGICAL: begin
			r = {operand[6:0], 1'b0};
			c = operand[7];
			flags_out[bfx_pkg::FL_H] = operand[3];
		end
		bfx_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
			r = {1'b0, operand[7:1]};
			c = operand[0];
		end
		bfx_pkg::OP_ROTATE_LEFT_CARRY: begin
			r = {operand[6:0], flags_in[bfx_pkg::FL_C]};
			c = operand[7];
		end
		bfx_pkg::OP_ROTATE_RIGHT_CARRY: begin
			r = {flags_in[bfx_pkg::FL_C], operand[7:1]};
			c = operand[0];
		end
		bfx_pkg::OP_SHIFT_RIGHT_ARITH: begin
			r = {operand[7], operand[7:1]};
			c = operand[0];
		end
		default: begin
			r = {operand[3:0], operand[7:4]};
		end
		endcase
		nf = r[7];
		// The swap keeps every flag, so only the shifts reach this point.
		if (op != bfx_pkg::OP_NIBBLE_SWAP) begin
			flags_out[bfx_pkg::FL_C] = c;
			flags_out[bfx_pkg::FL_Z] = (r == 8'h00);
			flags_out[bfx_pkg::FL_N] = nf;
			flags_out[bfx_pkg::FL_V] = nf ^ c;
		end
		// Only the left rotate also refreshes the sign flag.
		if (op == bfx_pkg::OP_ROTATE_LEFT_CARRY) begin
			flags_out[bfx_pkg::FL_S] = nf ^ (nf ^ c);
		end
		result = r;
	end
endmodule // bfx_shift_unit

// [test/bfx_exec_properties.sv]
/* Strobe timing checks for the executor, judged from the command write.
   Assumes commands are written only while the executor is idle. */
`timescale 1ns/1ps
module bfx_exec_checker (
	input wire logic core_clk,
	input wire logic resetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	input wire logic mem_we,
	input wire logic mem_re,
	input wire logic [5:0] io_addr,
	input wire logic [2:0] io_bit,
	input wire logic io_set,
	input wire logic io_clr
);
	logic cmd_dp;
	logic [4:0] op;
	default clocking @(posedge core_clk); endclocking
	default disable iff (!resetn);
	// Marks the data phase of a write to the command word.
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) cmd_dp <= 1'b0;
		else cmd_dp <= hsel && htrans[1] && hready && hwrite && haddr[7:2] == 6'h00;
	end
	assign op = hwdata[4:0];
	io_set_time_a: assert property (cmd_dp && op == 5'h08 |-> ##2 io_set && !io_clr
		&& io_bit == $past(hwdata[7:5], 2) && io_addr == $past(hwdata[29:24], 2))
		else $error("io set strobe wrong");
	io_clr_time_a: assert property (cmd_dp && op == 5'h09 |-> ##2 io_clr && !io_set
		&& io_bit == $past(hwdata[7:5], 2)) else $error("io clear strobe wrong");
	io_pulse_a: assert property (io_set || io_clr |=> !io_set && !io_clr)
		else $error("io strobe longer than one cycle");
	load_strobe_a: assert property (cmd_dp && op inside {5'h0E, 5'h0F}
		|-> !mem_re ##2 mem_re && !mem_we) else $error("load strobe wrong");
	store_strobe_a: assert property (cmd_dp && op == 5'h10 && hwdata[17:16] != 2'b10
		|-> ##2 mem_we && !mem_re) else $error("store strobe wrong");
	store_refuse_a: assert property (cmd_dp && op == 5'h10 && hwdata[17:16] == 2'b10
		|-> ##2 !mem_we && !mem_re) else $error("refused store strobed");
	mem_pulse_a: assert property (mem_re || mem_we |=> !mem_re && !mem_we)
		else $error("memory strobe longer than one cycle");
	shift_quiet_a: assert property (cmd_dp && op < 5'h08
		|-> ##1 (!(mem_re || mem_we || io_set || io_clr))[*3]) else $error("shift strobed");
	move_quiet_a: assert property (cmd_dp && op inside {[5'h0A:5'h0D]}
		|-> ##1 (!(mem_re || mem_we || io_set || io_clr))[*3]) else $error("move strobed");
	cover property (io_set);
	cover property (mem_re);
	cover property (mem_we);
endmodule // bfx_exec_checker
bind bfx_exec_top bfx_exec_checker chk_u (.core_clk(core_clk), .resetn(resetn),
	.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata),
	.hready(hready), .mem_we(mem_we), .mem_re(mem_re), .io_addr(io_addr),
	.io_bit(io_bit), .io_set(io_set), .io_clr(io_clr));

// [test/bfx_mem_model.sv]
/* Data memory and I/O register space beside the executor.
   Assumes one clock, registered strobes and a pointer space of 512 bytes. */
`timescale 1ns/1ps
module bfx_mem_model (
	input wire logic core_clk,
	input wire logic [15:0] mem_addr,
	input wire logic [7:0] mem_wdata,
	input wire logic mem_we,
	input wire logic mem_re,
	output logic [7:0] mem_rdata,
	input wire logic [5:0] io_addr,
	input wire logic [2:0] io_bit,
	input wire logic io_set,
	input wire logic io_clr
);
	logic [7:0] mem [0:511];
	logic [7:0] io [0:63];
	logic [7:0] last = 8'h00;
	// Outside a load the bus shows the inverse of the last byte, so stale data never matches.
	assign mem_rdata = mem_re ? mem[mem_addr[8:0]] : ~last;
	// Stores and bit strobes land at the edge that ends their cycle.
	always @(posedge core_clk) begin
		if (mem_re) last <= mem[mem_addr[8:0]];
		if (mem_we) mem[mem_addr[8:0]] <= mem_wdata;
		if (io_set) io[io_addr][io_bit] <= 1'b1;
		if (io_clr) io[io_addr][io_bit] <= 1'b0;
	end
endmodule // bfx_mem_model

// [test/bit_flag_transfer_exec_bench.sv]
/* Self-checking bench: AHB-Lite master tasks, scenarios and verdict.
   Assumes the memory model answers a load within the strobe cycle. */
`timescale 1ns/1ps
module bit_flag_transfer_exec_bench;
	logic core_clk = 1'b0;
	logic resetn = 1'b0;
	logic hsel = 1'b0;
	logic [31:0] haddr = 32'h0000_0000;
	logic [1:0] htrans = 2'b00;
	logic hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0000_0000;
	logic hreadyout, hresp, mem_we, mem_re, io_set, io_clr;
	logic [31:0] hrdata, q;
	logic [15:0] mem_addr;
	logic [7:0] mem_wdata, mem_rdata;
	logic [5:0] io_addr;
	logic [2:0] io_bit;
	int n_errors = 0;
	int n_compared = 0;
	// Clock at 10 MHz.
	always #50 core_clk = ~core_clk;
	bfx_exec_top dut_u (.core_clk(core_clk), .resetn(resetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .mem_addr(mem_addr),
		.mem_wdata(mem_wdata), .mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata),
		.io_addr(io_addr), .io_bit(io_bit), .io_set(io_set), .io_clr(io_clr));
	bfx_mem_model mdl_u (.core_clk(core_clk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
		.mem_we(mem_we), .mem_re(mem_re), .mem_rdata(mem_rdata), .io_addr(io_addr),
		.io_bit(io_bit), .io_set(io_set), .io_clr(io_clr));
	task automatic test_done();
		if (n_errors == 0 && n_compared > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask
	// One single transfer, entered just after an edge; either phase may be stretched.
	task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		htrans <= 2'b10;
		hwrite <= wr;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge core_clk);
		while (hreadyout !== 1'b1) @(posedge core_clk);
		q = hrdata;
	endtask
	function automatic logic [7:0] gpr(input logic [3:0] i);
		return bfx_pkg::ADDR_GPR_BASE + {2'b00, i, 2'b00};
	endfunction
	function automatic logic [31:0] cmd(input logic [4:0] op, input logic [2:0] b,
		input logic [3:0] d, input logic [3:0] s, input logic [1:0] p, input logic [1:0] m,
		input logic [7:0] imm);
		return {imm, 4'h0, m, p, s, d, b, op};
	endfunction
	// Issues a command, then polls busy; the poll is bounded so a hang shows up here.
	task automatic run(input logic [31:0] c);
		bus(1'b1, bfx_pkg::ADDR_CMD, c);
		// A write returns no read data, so the first poll is always made.
		bus(1'b0, bfx_pkg::ADDR_STATUS, 0);
		for (int k = 0; k < 8 && q[0] !== 1'b0; k++) bus(1'b0, bfx_pkg::ADDR_STATUS, 0);
		chk("status", q, 32'h0000_0000);
	endtask
	// Shifts, rotates and swap on a busy and a zero-producing operand.
	task automatic t_shift();
		logic [7:0] v, r;
		logic c, ci;
		for (int op = 0; op < 6; op++) begin
			for (int j = 0; j < 2; j++) begin
				v = j ? 8'h01 : 8'h96;
				ci = !j;
				case (op)
					0: {c, r} = {v, 1'b0};
					1: {r, c} = {1'b0, v};
					2: {c, r} = {v, ci};
					3: {r, c} = {ci, v};
					4: {r, c} = {v[7], v};
					default: {c, r} = {ci, v[3:0], v[7:4]};
				endcase
				bus(1'b1, gpr(4'h1), {24'h00_0000, v});
				bus(1'b1, bfx_pkg::ADDR_FLAGS, {24'h00_0000, 7'h60, ci});
				run(cmd(op[4:0], 3'h0, 4'h1, 4'h0, 2'b00, 2'b00, 8'h00));
				bus(1'b0, gpr(4'h1), 0);
				chk("shift result", q, {24'h00_0000, r});
				bus(1'b0, bfx_pkg::ADDR_FLAGS, 0);
				if (op == 5) chk("swap flags", q, {24'h00_0000, 7'h60, ci});
				else chk("shift flags", {q[7:6], q[2:0]}, {2'b11, r[7], r == 8'h00, c});
			end
		end
	endtask
	// Every flag index is set from all-clear and cleared from all-set.
	task automatic t_flag();
		for (int i = 0; i < 8; i++) begin
			bus(1'b1, bfx_pkg::ADDR_FLAGS, 32'h0000_0000);
			run(cmd(5'h06, i[2:0], 4'h0, 4'h0, 2'b00, 2'b00, 8'h00));
			bus(1'b0, bfx_pkg::ADDR_FLAGS, 0);
			chk("flag set", q, 32'h1 << i);
			bus(1'b1, bfx_pkg::ADDR_FLAGS, 32'h0000_00FF);
			run(cmd(5'h07, i[2:0], 4'h0, 4'h0, 2'b00, 2'b00, 8'h00));
			bus(1'b0, bfx_pkg::ADDR_FLAGS, 0);
			chk("flag clear", q, 32'h0000_00FF ^ (32'h1 << i));
		end
	endtask
	// Transfer flag both ways, copy, immediate load and the I/O bit strobes.
	task automatic t_xfer();
		bus(1'b1, gpr(4'h2), 32'h0000_0020);
		bus(1'b1, gpr(4'h3), 32'h0000_0080);
		bus(1'b1, bfx_pkg::ADDR_FLAGS, 32'h0000_00BF);
		run(cmd(5'h0A, 3'h5, 4'h0, 4'h2, 2'b00, 2'b00, 8'h00));
		run(cmd(5'h0B, 3'h0, 4'h3, 4'h0, 2'b00, 2'b00, 8'h00));
		run(cmd(5'h0C, 3'h0, 4'h4, 4'h3, 2'b00, 2'b00, 8'h00));
		run(cmd(5'h0D, 3'h0, 4'h5, 4'h0, 2'b00, 2'b00, 8'hA5));
		run(cmd(5'h08, 3'h3, 4'h0, 4'h0, 2'b00, 2'b00, 8'h2A));
		chk("io set", {24'h00_0000, mdl_u.io[42]}, 32'h0000_0008);
		run(cmd(5'h08, 3'h7, 4'h0, 4'h0, 2'b00, 2'b00, 8'h2A));
		run(cmd(5'h09, 3'h3, 4'h0, 4'h0, 2'b00, 2'b00, 8'h2A));
		chk("io clear", {24'h00_0000, mdl_u.io[42]}, 32'h0000_0080);
		bus(1'b0, gpr(4'h4), 0);
		chk("copy", q, 32'h0000_0081);
		bus(1'b0, gpr(4'h5), 0);
		chk("immediate", q, 32'h0000_00A5);
		bus(1'b0, bfx_pkg::ADDR_FLAGS, 0);
		chk("flags after moves", q, 32'h0000_00FF);
	endtask
	// Pointer loads and stores in plain, post-increment and pre-decrement modes from 0x0100, plus one direct load.
	task automatic t_mem();
		logic [15:0] a, e;
		logic [3:0] lo;
		logic [7:0] v;
		bus(1'b1, bfx_pkg::ADDR_FLAGS, 32'h0000_003C);
		for (int s = 0; s < 2; s++) begin
			for (int p = 0; p < 3 - s; p++) begin
				for (int m = 0; m < 3; m++) begin
					lo = 4'(10 + 2 * p);
					v = 8'(8'hC0 + 3 * p + m);
					a = (m == 2) ? 16'h00FF : 16'h0100;
					e = (m == 1) ? 16'h0101 : a;
					bus(1'b1, gpr(lo), 32'h0000_0000);
					bus(1'b1, gpr(lo + 4'h1), 32'h0000_0001);
					bus(1'b1, gpr(4'h6), {24'h00_0000, v});
					run(cmd(s ? 5'h10 : 5'h0E, 3'h0, 4'h2, 4'h6, p[1:0], m[1:0], 8'h00));
					bus(1'b0, gpr(4'h2), 0);
					if (s == 0) chk("load", q, {24'h00_0000, a[7:0] ^ 8'h5A});
					else chk("store", {24'h00_0000, mdl_u.mem[a[8:0]]}, {24'h00_0000, v});
					bus(1'b0, gpr(lo), 0);
					chk("pointer low", q, {24'h00_0000, e[7:0]});
					bus(1'b0, gpr(lo + 4'h1), 0);
					chk("pointer high", q, {24'h00_0000, e[15:8]});
				end
			end
		end
		bus(1'b1, bfx_pkg::ADDR_OPERAND, 32'h0000_0123);
		run(cmd(5'h0F, 3'h0, 4'h7, 4'h0, 2'b00, 2'b00, 8'h00));
		bus(1'b0, gpr(4'h7), 0);
		chk("direct load", q, 32'h0000_0079);
		bus(1'b0, bfx_pkg::ADDR_FLAGS, 0);
		chk("flags after memory", q, 32'h0000_003C);
		// A store through Z is refused: only the sticky bit moves, and a write of one clears it.
		bus(1'b1, bfx_pkg::ADDR_CMD, cmd(5'h10, 3'h0, 4'h0, 4'h6, 2'b10, 2'b00, 8'h00));
		bus(1'b0, bfx_pkg::ADDR_STATUS, 0);
		bus(1'b0, bfx_pkg::ADDR_STATUS, 0);
		chk("refused", q, 32'h0000_0002);
		bus(1'b1, bfx_pkg::ADDR_STATUS, 32'h0000_0002);
		bus(1'b0, bfx_pkg::ADDR_STATUS, 0);
		chk("refused clear", q, 32'h0000_0000);
	endtask
	// Cuts a hang short well past the expected run of under a thousand cycles.
	initial begin
		repeat (40000) @(posedge core_clk);
		n_errors++;
		test_done();
	end
	// Memory pattern, reset, then the scenarios in turn.
	initial begin
		for (int i = 0; i < 512; i++) mdl_u.mem[i] = 8'(i) ^ 8'h5A;
		for (int i = 0; i < 64; i++) mdl_u.io[i] = 8'h00;
		repeat (12) @(posedge core_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge core_clk);
		bus(1'b0, bfx_pkg::ADDR_FLAGS, 0);
		chk("flags reset", q, {24'h00_0000, bfx_pkg::FLAGS_RST});
		t_shift();
		t_flag();
		t_xfer();
		t_mem();
		test_done();
	end
endmodule // bit_flag_transfer_exec_bench
